// ===== afc_modbus_regs.sv
/*
  Operation register bank of the airflow controller: writable setpoint,
  override and service command, read-only measurements.
  Assumes the protocol engine issues one-cycle word reads/writes on this
  clock and keeps 32-bit pairs whole; measured values come from on-chip
  logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module afc_modbus_regs
  import afc_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  output logic      [DATA_W-1:0]  reg_rdata,
  output logic                    reg_ack,
  output logic                    reg_err,
  input  wire logic [1:0]         setpoint_source,
  input  wire logic [1:0]         application_sel,
  input  wire logic               control_mode,
  input  wire logic               has_local_actuator,
  input  wire logic [DATA_W-1:0]  min_limit,
  input  wire logic [DATA_W-1:0]  max_limit,
  input  wire logic [DATA_W-1:0]  drive_kind_in,
  input  wire logic [DATA_W-1:0]  relative_position_in,
  input  wire logic [DATA_W-1:0]  absolute_angle_in,
  input  wire logic [DATA_W-1:0]  relative_flow_in,
  input  wire logic [DATA_W-1:0]  absolute_flow_in,
  input  wire logic [DATA_W-1:0]  sensor_reading_in,
  input  wire logic [31:0]        flow_units_in,
  input  wire logic [DATA_W-1:0]  analog_setpoint_in,
  input  wire logic [DATA_W-1:0]  relative_dp_in,
  input  wire logic [DATA_W-1:0]  absolute_dp_in,
  input  wire logic [31:0]        dp_units_in,
  input  wire logic               termination_enabled,
  input  wire logic               service_done,
  output logic                    start_adaptation,
  output logic                    start_sync,
  output logic                    service_busy,
  output logic      [DATA_W-1:0]  demand_value,
  output logic      [1:0]         demand_kind,
  output logic      [3:0]         override_active,
  output logic                    override_on
);

  logic [DATA_W-1:0]  bus_setpoint;
  logic [DATA_W-1:0]  override_select;
  logic [DATA_W-1:0]  service_command;
  afc_cmd_state_type  cmd_state;
  afc_cmd_state_type  next_cmd_state;
  logic [DATA_W-1:0]  selected_setpoint;
  logic [DATA_W-1:0]  span;
  logic [31:0]        scaled;
  logic               pressure_app;
  logic               flow_valid;
  logic [DATA_W-1:0]  next_rdata;
  logic               next_err;
  logic [31:0]        flow_clip;
  logic [31:0]        dp_clip;
  logic [DATA_W-1:0]  abs_dp_clip;

  assign pressure_app = (application_sel == APP_PRESSURE) ||
                        (application_sel == APP_ROOM_PRESS);
  assign flow_valid   = !pressure_app;

  // Setpoint register: out-of-range writes are clipped rather than refused
  always_ff @(posedge clock) begin
    if (rst) begin
      bus_setpoint <= REG_RESET;
    end else if (reg_wr && reg_addr == ADDR_BUS_SETPOINT) begin
      bus_setpoint <= (reg_wdata > SETPOINT_MAX) ? SETPOINT_MAX : reg_wdata;
    end
  end

  // Unused override codes are dropped so the register only holds legal values
  always_ff @(posedge clock) begin
    if (rst) begin
      override_select <= REG_RESET;
    end else if (reg_wr && reg_addr == ADDR_OVERRIDE_SELECT) begin
      case (reg_wdata)
        16'(OVR_NONE), 16'(OVR_OPEN), 16'(OVR_CLOSE),
        16'(OVR_MIN), 16'(OVR_MAX), 16'(OVR_STOP): begin
          override_select <= reg_wdata;
        end
        default: begin
          override_select <= override_select;
        end
      endcase
    end
  end

  // Command sequencer: start pulse, wait for done, then clear the register
  always_comb begin
    next_cmd_state = cmd_state;
    case (cmd_state)
      ST_IDLE: begin
        if (reg_wr && reg_addr == ADDR_SERVICE_COMMAND &&
            (reg_wdata == 16'(CMD_ADAPT) || reg_wdata == 16'(CMD_SYNC))) begin
          next_cmd_state = ST_START;
        end
      end
      ST_START: begin
        next_cmd_state = ST_BUSY;
      end
      ST_BUSY: begin
        if (service_done) begin
          next_cmd_state = ST_IDLE;
        end
      end
      default: begin
        next_cmd_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_state <= ST_IDLE;
    end else begin
      cmd_state <= next_cmd_state;
    end
  end

  // Writes while a function runs are ignored; the register self-clears on done
  always_ff @(posedge clock) begin
    if (rst) begin
      service_command <= REG_RESET;
    end else if (cmd_state == ST_BUSY && service_done) begin
      service_command <= REG_RESET;
    end else if (cmd_state == ST_IDLE && next_cmd_state == ST_START) begin
      service_command <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      start_adaptation <= 1'b0;
      start_sync       <= 1'b0;
    end else begin
      start_adaptation <= (cmd_state == ST_START) &&
                          (service_command == 16'(CMD_ADAPT));
      start_sync       <= (cmd_state == ST_START) &&
                          (service_command == 16'(CMD_SYNC));
    end
  end

  assign service_busy = (cmd_state != ST_IDLE);

  // Setpoint path
  always_comb begin
    if (setpoint_source == SRC_BUS) begin
      selected_setpoint = bus_setpoint;
    end else begin
      selected_setpoint = analog_setpoint_in;
    end
  end

  // Guard min > max so the span never wraps negative
  assign span   = (max_limit > min_limit) ? (max_limit - min_limit) : ZERO_WORD;
  assign scaled = (32'(selected_setpoint) * 32'(span)) / 32'(SETPOINT_MAX);

  always_ff @(posedge clock) begin
    if (rst) begin
      demand_value <= REG_RESET;
      demand_kind  <= 2'(DEM_FLOW);
    end else begin
      case (override_select[$bits(afc_override_type)-1:0])
        4'(OVR_OPEN):  demand_value <= SETPOINT_MAX;
        4'(OVR_CLOSE): demand_value <= ZERO_WORD;
        4'(OVR_MIN):   demand_value <= min_limit;
        4'(OVR_MAX):   demand_value <= max_limit;
        4'(OVR_STOP):  demand_value <= demand_value;
        default:       demand_value <= min_limit + scaled[DATA_W-1:0];
      endcase
      if (pressure_app) begin
        demand_kind <= 2'(DEM_PRESSURE);
      end else if (control_mode == MODE_POSITION) begin
        demand_kind <= 2'(DEM_POSITION);
      end else begin
        demand_kind <= 2'(DEM_FLOW);
      end
    end
  end

  assign override_active = override_select[$bits(afc_override_type)-1:0];
  assign override_on     = (override_select != REG_RESET);

  // Clip measurement inputs to their documented ranges
  assign flow_clip   = (flow_units_in > FLOW_UNITS_MAX) ? FLOW_UNITS_MAX : flow_units_in;
  assign dp_clip     = ($signed(dp_units_in) > DP_UNITS_MAX) ? DP_UNITS_MAX :
                       ($signed(dp_units_in) < DP_UNITS_MIN) ? DP_UNITS_MIN :
                       dp_units_in;
  assign abs_dp_clip = ($signed(absolute_dp_in) > ABS_DP_MAX) ? ABS_DP_MAX :
                       ($signed(absolute_dp_in) < ABS_DP_MIN) ? ABS_DP_MIN :
                       absolute_dp_in;

  // Read mux; read-only addresses have no write path at all
  always_comb begin
    next_rdata = ZERO_WORD;
    next_err   = 1'b0;
    case (reg_addr)
      ADDR_BUS_SETPOINT:      next_rdata = bus_setpoint;
      ADDR_OVERRIDE_SELECT:   next_rdata = override_select;
      ADDR_SERVICE_COMMAND:   next_rdata = service_command;
      ADDR_DRIVE_KIND:        next_rdata = has_local_actuator ? drive_kind_in :
                                           INACTIVE_VALUE;
      ADDR_RELATIVE_POSITION: next_rdata = !has_local_actuator ? INACTIVE_VALUE :
                                           (relative_position_in > REL_POS_MAX) ? REL_POS_MAX :
                                           relative_position_in;
      ADDR_ABSOLUTE_ANGLE:    next_rdata = !has_local_actuator ? INACTIVE_VALUE :
                                           (absolute_angle_in > ANGLE_MAX) ? ANGLE_MAX :
                                           absolute_angle_in;
      ADDR_RELATIVE_FLOW:     next_rdata = !flow_valid ? INACTIVE_VALUE :
                                           (relative_flow_in > REL_FLOW_MAX) ? REL_FLOW_MAX :
                                           relative_flow_in;
      ADDR_ABSOLUTE_FLOW:     next_rdata = flow_valid ? absolute_flow_in :
                                           INACTIVE_VALUE;
      ADDR_SENSOR_READING:    next_rdata = sensor_reading_in;
      ADDR_GAP_A:             next_rdata = ZERO_WORD;
      ADDR_FLOW_UNITS_LOW:    next_rdata = flow_valid ? flow_clip[DATA_W-1:0] :
                                           INACTIVE_VALUE;
      ADDR_FLOW_UNITS_HIGH:   next_rdata = flow_valid ? flow_clip[2*DATA_W-1:DATA_W] :
                                           INACTIVE_VALUE;
      ADDR_ANALOG_SETPOINT:   next_rdata = (setpoint_source != SRC_ANALOG) ? INACTIVE_VALUE :
                                           (analog_setpoint_in > SETPOINT_MAX) ? SETPOINT_MAX :
                                           analog_setpoint_in;
      ADDR_RELATIVE_DP:       next_rdata = (relative_dp_in > REL_DP_MAX) ? REL_DP_MAX :
                                           relative_dp_in;
      ADDR_ABSOLUTE_DP:       next_rdata = abs_dp_clip;
      ADDR_GAP_B:             next_rdata = ZERO_WORD;
      ADDR_DP_UNITS_LOW:      next_rdata = dp_clip[DATA_W-1:0];
      ADDR_DP_UNITS_HIGH:     next_rdata = dp_clip[2*DATA_W-1:DATA_W];
      ADDR_LINE_TERMINATION:  next_rdata = DATA_W'(termination_enabled);
      default: begin
        next_rdata = INACTIVE_VALUE;
        next_err   = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= ZERO_WORD;
      reg_ack   <= 1'b0;
      reg_err   <= 1'b0;
    end else begin
      reg_ack <= reg_rd || reg_wr;
      reg_err <= (reg_rd || reg_wr) && next_err;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule
`default_nettype wire

// ===== afc_pkg.sv
/*
  Constants of the airflow controller operation register bank: register
  addresses, codes, limits and reset values.
  Assumes a word-addressed register access port driven by the serial
  protocol engine on the same clock.
*/
// Contract
// - Bus setpoint 0..10000, resets to zero
// - Bus setpoint used only when source is bus
// - Setpoint scaled linearly between min and max
// - Flow application: setpoint means demanded flow
// - Flow plus position mode: setpoint means position
// - Pressure applications: setpoint means demanded pressure
// - Override codes 0,1,2,3,5,8; reset zero
// - Active override replaces the selected setpoint
// - Command starts adaptation/sync, self-clears when done
// - No local actuator: actuator registers read 65535
// - Relative position 0..10000, read-only
// - Absolute angle 0..9600 hundredths degree
// - Relative flow 0..15000, read-only
// - Pressure applications: flow registers read 65535
// - Flow 32-bit, low word 10, high 11
// - Sensor register reports raw unscaled reading
// - Analog setpoint view active when source analog
// - Relative pressure 0..20000 hundredths percent
// - Absolute pressure signed -1000..10000 tenths pascal
// - Pressure 32-bit signed, low 53, high 54
// - Termination register reads enable state, read-only
// - Unsupported registers read all ones
// - Signed registers use two's complement
package afc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  localparam logic [ADDR_W-1:0] ADDR_BUS_SETPOINT        = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_OVERRIDE_SELECT     = 16'h0001;
  localparam logic [ADDR_W-1:0] ADDR_SERVICE_COMMAND     = 16'h0002;
  localparam logic [ADDR_W-1:0] ADDR_DRIVE_KIND          = 16'h0003;
  localparam logic [ADDR_W-1:0] ADDR_RELATIVE_POSITION   = 16'h0004;
  localparam logic [ADDR_W-1:0] ADDR_ABSOLUTE_ANGLE      = 16'h0005;
  localparam logic [ADDR_W-1:0] ADDR_RELATIVE_FLOW       = 16'h0006;
  localparam logic [ADDR_W-1:0] ADDR_ABSOLUTE_FLOW       = 16'h0007;
  localparam logic [ADDR_W-1:0] ADDR_SENSOR_READING      = 16'h0008;
  localparam logic [ADDR_W-1:0] ADDR_GAP_A               = 16'h0009;
  localparam logic [ADDR_W-1:0] ADDR_FLOW_UNITS_LOW      = 16'h000A;
  localparam logic [ADDR_W-1:0] ADDR_FLOW_UNITS_HIGH     = 16'h000B;
  localparam logic [ADDR_W-1:0] ADDR_ANALOG_SETPOINT     = 16'h000C;
  localparam logic [ADDR_W-1:0] ADDR_RELATIVE_DP         = 16'h0032;
  localparam logic [ADDR_W-1:0] ADDR_ABSOLUTE_DP         = 16'h0033;
  localparam logic [ADDR_W-1:0] ADDR_GAP_B               = 16'h0034;
  localparam logic [ADDR_W-1:0] ADDR_DP_UNITS_LOW        = 16'h0035;
  localparam logic [ADDR_W-1:0] ADDR_DP_UNITS_HIGH       = 16'h0036;
  localparam logic [ADDR_W-1:0] ADDR_LINE_TERMINATION    = 16'h0063;

  localparam logic [DATA_W-1:0] INACTIVE_VALUE   = 16'hFFFF;
  localparam logic [DATA_W-1:0] ZERO_WORD        = 16'h0000;
  localparam logic [DATA_W-1:0] SETPOINT_MAX     = 16'h2710;  // 10000
  localparam logic [DATA_W-1:0] REL_POS_MAX      = 16'h2710;  // 10000
  localparam logic [DATA_W-1:0] ANGLE_MAX        = 16'h2580;  // 9600
  localparam logic [DATA_W-1:0] REL_FLOW_MAX     = 16'h3A98;  // 15000
  localparam logic [DATA_W-1:0] REL_DP_MAX       = 16'h4E20;  // 20000
  localparam logic signed [DATA_W-1:0] ABS_DP_MIN = 16'shFC18; // -1000
  localparam logic signed [DATA_W-1:0] ABS_DP_MAX = 16'sh2710; // 10000
  localparam logic [31:0] FLOW_UNITS_MAX = 32'h1DCD_6500;      // 500000000
  localparam logic signed [31:0] DP_UNITS_MIN = 32'shFF67_6980; // -10000000
  localparam logic signed [31:0] DP_UNITS_MAX = 32'sh05F5_E100; // 100000000
  localparam logic [DATA_W-1:0] REG_RESET      = 16'h0000;

  localparam logic [1:0] SRC_ANALOG = 2'h0;
  localparam logic [1:0] SRC_BUS    = 2'h1;

  localparam logic [1:0] APP_FLOW         = 2'h0;
  localparam logic [1:0] APP_PRESSURE     = 2'h1;
  localparam logic [1:0] APP_ROOM_PRESS   = 2'h2;

  localparam logic MODE_POSITION = 1'b0;

  typedef enum logic [3:0] {
    OVR_NONE  = 4'h0,
    OVR_OPEN  = 4'h1,
    OVR_CLOSE = 4'h2,
    OVR_MIN   = 4'h3,
    OVR_MAX   = 4'h5,
    OVR_STOP  = 4'h8
  } afc_override_type;

  typedef enum logic [1:0] {
    CMD_NONE  = 2'h0,
    CMD_ADAPT = 2'h1,
    CMD_SYNC  = 2'h2
  } afc_command_type;

  typedef enum logic [1:0] {
    DEM_FLOW     = 2'h0,
    DEM_POSITION = 2'h1,
    DEM_PRESSURE = 2'h2
  } afc_demand_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_START = 3'b010,
    ST_BUSY  = 3'b100
  } afc_cmd_state_type;
endpackage

// ===== afc_regs_chk_sva.sv
/* Concurrent checks on the operation register bank ports.
   Assumes one clock and the synchronous active-high reset of the bank. */
`timescale 1ns/10ps
`default_nettype none
module afc_regs_chk
  import afc_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              reg_ack,
  input wire logic              reg_err,
  input wire logic [1:0]        application_sel,
  input wire logic              has_local_actuator,
  input wire logic              termination_enabled,
  input wire logic              service_done,
  input wire logic              start_adaptation,
  input wire logic              start_sync,
  input wire logic              service_busy,
  input wire logic [3:0]        override_active,
  input wire logic              override_on
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_cmd(logic [15:0] c);
    reg_wr && reg_addr == 16'h0002 && reg_wdata == c && !service_busy && !service_done;
  endsequence
  sequence s_go(logic p);
    service_busy ##1 p;
  endsequence
  sequence s_ovr;
    reg_wr && reg_addr == 16'h0001;
  endsequence
  property p_ack;
    (reg_rd || reg_wr) |=> reg_ack;
  endproperty
  property p_quiet;
    !(reg_rd || reg_wr) |=> !reg_ack && !reg_err;
  endproperty
  property p_gap;
    reg_rd && (reg_addr == 16'h0009 || reg_addr == 16'h0034) |=> reg_rdata == 16'h0000 && !reg_err;
  endproperty
  property p_act;
    reg_rd && reg_addr inside {16'h0003, 16'h0004, 16'h0005} && !has_local_actuator
      |=> reg_rdata == 16'hFFFF;
  endproperty
  property p_flow;
    reg_rd && reg_addr inside {16'h0006, 16'h0007, 16'h000A, 16'h000B}
      && application_sel inside {2'h1, 2'h2} |=> reg_rdata == 16'hFFFF;
  endproperty
  property p_term;
    reg_rd && reg_addr == 16'h0063 |=> reg_rdata == {15'h0000, $past(termination_enabled)};
  endproperty
  property p_adapt;
    s_cmd(16'h0001) |=> s_go(start_adaptation);
  endproperty
  property p_sync;
    s_cmd(16'h0002) |=> s_go(start_sync);
  endproperty
  property p_done;
    service_busy && service_done |=> !service_busy;
  endproperty
  property p_ovr;
    s_ovr ##0 reg_wdata inside {16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0005, 16'h0008}
      |=> {12'h000, override_active} == $past(reg_wdata) && override_on == (override_active != 4'h0);
  endproperty
  property p_ovr_keep;
    s_ovr ##0 !(reg_wdata inside {16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0005, 16'h0008})
      |=> $stable(override_active);
  endproperty
  a_ack: assert property (p_ack) else $error("request without acknowledge");
  a_quiet: assert property (p_quiet) else $error("acknowledge without request");
  a_gap: assert property (p_gap) else $error("gap address not zero");
  a_act: assert property (p_act) else $error("actuator register active");
  a_flow: assert property (p_flow) else $error("flow register active");
  a_term: assert property (p_term) else $error("termination state wrong");
  a_adapt: assert property (p_adapt) else $error("adaptation not started");
  a_sync: assert property (p_sync) else $error("sync not started");
  a_done: assert property (p_done) else $error("busy after done");
  a_ovr: assert property (p_ovr) else $error("override code not taken");
  a_ovr_keep: assert property (p_ovr_keep) else $error("unused override code taken");
endmodule
bind afc_modbus_regs afc_regs_chk u_chk (.*);
`default_nettype wire

// ===== afc_master_model.sv
/* Register access master standing in for the serial protocol engine.
   Assumes one-cycle strobes and an acknowledge on the next cycle. */
`timescale 1ns/10ps
`default_nettype none
module afc_master_model
  import afc_pkg::*;
(
  input  wire logic              clock,
  input  wire logic [DATA_W-1:0] reg_rdata,
  input  wire logic              reg_ack,
  input  wire logic              reg_err,
  output var logic               reg_wr,
  output var logic               reg_rd,
  output var logic [ADDR_W-1:0]  reg_addr,
  output var logic [DATA_W-1:0]  reg_wdata
);
  int gap = 0;
  int lost = 0;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
  end
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic e);
    int n;
    n = 0;
    repeat (gap) @(posedge clock);
    @(posedge clock);
    #1;
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // Released lines toggle so a stale value is never mistaken for a live one
    reg_addr = ~a;
    reg_wdata = ~d;
    while (reg_ack !== 1'b1 && n < 8) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 8) lost++;
    q = reg_rdata;
    e = reg_err;
  endtask
  // A 32-bit value is fetched as two separate word reads, low word first
  task automatic rd_pair(input logic [15:0] a, output logic [31:0] v);
    logic [15:0] lo;
    logic [15:0] hi;
    logic        e;
    xfer(1'b0, a, 16'h0000, lo, e);
    xfer(1'b0, a + 16'h0001, 16'h0000, hi, e);
    v = {hi, lo};
  endtask
endmodule
`default_nettype wire

// ===== test_airflow_ctrl_modbus_regs.sv
/* Self-checking bench of the operation register bank.
   Assumes the bank and its checker are compiled alongside. */
`timescale 1ns/10ps
`default_nettype none
module test_airflow_ctrl_modbus_regs
  import afc_pkg::*;
;
  logic clock = 1'b0, rst = 1'b1, service_done = 1'b0, control_mode = 1'b1;
  logic has_local_actuator = 1'b1, termination_enabled = 1'b0;
  logic reg_wr, reg_rd, reg_ack, reg_err, start_adaptation, start_sync, service_busy;
  logic override_on, e;
  logic [1:0] setpoint_source = SRC_BUS, application_sel = APP_FLOW, demand_kind;
  logic [15:0] min_limit = 16'h0000, max_limit = 16'h2710, drive_kind_in = 16'h0001;
  logic [15:0] relative_position_in = 16'h0000, absolute_angle_in = 16'h0000;
  logic [15:0] relative_flow_in = 16'h0000, absolute_flow_in = 16'h0000;
  logic [15:0] sensor_reading_in = 16'h0000, analog_setpoint_in = 16'h0000;
  logic [15:0] relative_dp_in = 16'h0000, absolute_dp_in = 16'h0000;
  logic [31:0] flow_units_in = 32'h0, dp_units_in = 32'h0, v;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, demand_value, q, sp, ov, dm;
  logic [3:0] override_active;
  logic [15:0] lst [17] = '{16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007, 16'h0008,
    16'h0009, 16'h000A, 16'h000B, 16'h000C, 16'h0032, 16'h0033, 16'h0034, 16'h0035,
    16'h0036, 16'h0063, 16'h0020};
  logic [15:0] spv [5] = '{16'h0000, 16'h2710, 16'h2711, 16'hFFFF, 16'h1234};
  logic [15:0] oc [7] = '{16'h0001, 16'h0002, 16'h0003, 16'h0005, 16'h0008, 16'h0004, 16'h0000};
  int failures = 0, total_checks = 0, i, j, k;
  always #5 clock = ~clock;
  afc_modbus_regs DUT (.*);
  afc_master_model M (.*);
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask
  task test_done;
    failures = failures + M.lost;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    M.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input logic [15:0] a);
    M.xfer(1'b0, a, 16'h0000, q, e);
  endtask
  task settle;
    repeat (3) @(posedge clock);
    #1;
  endtask
  function logic [15:0] scale(input logic [15:0] s);
    int t;
    t = int'(min_limit) + int'(s) * (int'(max_limit) - int'(min_limit)) / int'(SETPOINT_MAX);
    return 16'(t);
  endfunction
  function logic [15:0] exp_rd(input logic [15:0] a);
    logic na;
    logic nf;
    na = !has_local_actuator;
    nf = application_sel == APP_PRESSURE || application_sel == APP_ROOM_PRESS;
    case (a)
      16'h0003: exp_rd = na ? 16'hFFFF : drive_kind_in;
      16'h0004: exp_rd = na ? 16'hFFFF : relative_position_in;
      16'h0005: exp_rd = na ? 16'hFFFF : absolute_angle_in;
      16'h0006: exp_rd = nf ? 16'hFFFF : relative_flow_in;
      16'h0007: exp_rd = nf ? 16'hFFFF : absolute_flow_in;
      16'h0008: exp_rd = sensor_reading_in;
      16'h0009, 16'h0034: exp_rd = 16'h0000;
      16'h000A: exp_rd = nf ? 16'hFFFF : flow_units_in[15:0];
      16'h000B: exp_rd = nf ? 16'hFFFF : flow_units_in[31:16];
      16'h000C: exp_rd = setpoint_source == SRC_ANALOG ? analog_setpoint_in : 16'hFFFF;
      16'h0032: exp_rd = relative_dp_in;
      16'h0033: exp_rd = absolute_dp_in;
      16'h0035: exp_rd = dp_units_in[15:0];
      16'h0036: exp_rd = dp_units_in[31:16];
      16'h0063: exp_rd = {15'h0000, termination_enabled};
      default: exp_rd = 16'hFFFF;
    endcase
  endfunction
  // Upper corners of position, angle, relative flow and relative pressure on the last pass, random values otherwise
  task shuffle(input int n);
    application_sel = 2'(n % 3);
    setpoint_source = 2'(n / 3);
    has_local_actuator = n[0];
    termination_enabled = n[1];
    M.gap = $urandom_range(2);
    drive_kind_in = 16'($urandom_range(5, 1));
    relative_position_in = 16'($urandom_range(REL_POS_MAX, n == 5 ? REL_POS_MAX : 0));
    absolute_angle_in = 16'($urandom_range(ANGLE_MAX, n == 5 ? ANGLE_MAX : 0));
    relative_flow_in = 16'($urandom_range(REL_FLOW_MAX, n == 5 ? REL_FLOW_MAX : 0));
    absolute_flow_in = 16'($urandom);
    sensor_reading_in = 16'($urandom);
    analog_setpoint_in = 16'($urandom_range(SETPOINT_MAX));
    relative_dp_in = 16'($urandom_range(REL_DP_MAX, n == 5 ? REL_DP_MAX : 0));
    absolute_dp_in = 16'($urandom_range(16'h2AF8)) + ABS_DP_MIN;
    flow_units_in = $urandom_range(FLOW_UNITS_MAX);
    dp_units_in = $urandom_range(32'h068E_7780) + DP_UNITS_MIN;
  endtask
  initial begin
    #500000;
    failures++;
    test_done;
  end
  initial begin
    void'($urandom(32'h9523));
    repeat (16) @(posedge clock);
    #1 rst = 1'b0;
    for (i = 0; i < 3; i++) begin
      rd(16'(i));
      chk("reset value", 0, q);
    end
    rd(16'h0063);
    chk("termination", 0, q);
    $display("test reset done");
    for (i = 0; i < 6; i++) begin
      shuffle(i);
      for (j = 0; j < 17; j++) begin
        wr(lst[j], 16'($urandom));
        rd(lst[j]);
        chk("read map", exp_rd(lst[j]), q);
        chk("unmapped flag", lst[j] == 16'h0020, e);
      end
      M.rd_pair(16'h000A, v);
      chk("flow pair", {exp_rd(16'h000B), exp_rd(16'h000A)}, v);
      M.rd_pair(16'h0035, v);
      chk("pressure pair", {exp_rd(16'h0036), exp_rd(16'h0035)}, v);
    end
    $display("test read map done");
    setpoint_source = SRC_BUS;
    min_limit = 16'($urandom_range(16'h1388));
    max_limit = 16'($urandom_range(SETPOINT_MAX, min_limit));
    for (k = 0; k < 5; k++) begin
      wr(16'h0000, spv[k]);
      rd(16'h0000);
      sp = spv[k] > SETPOINT_MAX ? SETPOINT_MAX : spv[k];
      chk("setpoint", sp, q);
      for (j = 0; j < 4; j++) begin
        application_sel = j < 2 ? APP_FLOW : 2'(j - 1);
        control_mode = j != 1;
        settle();
        chk("kind", j == 0 ? DEM_FLOW : j == 1 ? DEM_POSITION : DEM_PRESSURE, demand_kind);
        chk("demand", scale(sp), demand_value);
      end
    end
    setpoint_source = SRC_ANALOG;
    wr(16'h0000, 16'h0000);
    settle();
    chk("analog demand", scale(analog_setpoint_in), demand_value);
    $display("test setpoint done");
    for (i = 0; i < 2; i++) begin
      setpoint_source = 2'(i);
      wr(16'h0000, sp);
      ov = 16'h0000;
      dm = 16'h0000;
      for (k = 0; k < 7; k++) begin
        wr(16'h0001, oc[k]);
        if (oc[k] != 16'h0004) ov = oc[k];
        dm = ov == 1 ? 16'h2710 : ov == 2 ? 16'h0000 : ov == 3 ? min_limit : ov == 5 ? max_limit
           : ov == 8 ? dm : scale(i == 1 ? sp : analog_setpoint_in);
        settle();
        rd(16'h0001);
        chk("override", ov, q);
        chk("override on", ov != 0, override_on);
        chk("override demand", dm, demand_value);
      end
    end
    $display("test override done");
    for (k = 1; k < 3; k++) begin
      wr(16'h0002, 16'(k));
      rd(16'h0002);
      chk("command", k, q);
      chk("busy", 1, service_busy);
      wr(16'h0002, 16'(3 - k));
      rd(16'h0002);
      chk("command held", k, q);
      @(posedge clock);
      #1 service_done = 1'b1;
      @(posedge clock);
      #1 service_done = 1'b0;
      rd(16'h0002);
      chk("command cleared", 0, q);
      chk("idle", 0, service_busy);
    end
    wr(16'h0002, 16'h0003);
    rd(16'h0002);
    chk("unused command", 0, q);
    $display("test command done");
    test_done;
  end
endmodule
`default_nettype wire
